// [logic/cevr_defs.svh]
// register offsets, field positions and reset values of the comparator block
`ifndef CEVR_DEFS_SVH
`define CEVR_DEFS_SVH
`define CEVR_OFS_STAT    32'h0000_2300
`define CEVR_OFS_CMP1    32'h0000_2310
`define CEVR_CMP_STRIDE  32'h0000_0020
`define CEVR_OFS_REF     32'h0000_2360
`define CEVR_OFS_IRQST   32'h0000_2370
`define CEVR_OFS_IRQMSK  32'h0000_2374
`define CEVR_B_ON        15
`define CEVR_B_PINDRV    14
`define CEVR_B_INV       13
`define CEVR_B_FLAG      9
`define CEVR_B_RES       8
`define CEVR_B_EDGE      6
`define CEVR_B_PLUS      4
`define CEVR_B_MINUS     0
`define CEVR_B_STFLAG    16
`define CEVR_B_PICK      8
`define CEVR_B_LEVEL     16
`define CEVR_B_REFON     15
`define CEVR_B_REFOE     8
`define CEVR_B_REFSRC    0
`define CEVR_RST_WORD    32'h0000_0000
`endif

// [logic/cevr_pkg.sv]
// types shared by the comparator and reference control files
`default_nettype none
package cevr_pkg;
	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_ANY  = 2'b11
	} cevr_edge_e;
	typedef struct packed {
		logic       en;
		logic       pinDrv;
		logic       inv;
		logic [1:0] edgeSel;
		logic       plusSel;
		logic [1:0] minusSel;
	} cevr_cmpctl_s;
	typedef struct packed {
		logic       en;
		logic [4:0] level;
		logic       pinOe;
		logic [1:0] src;
	} cevr_refctl_s;
endpackage : cevr_pkg
`default_nettype wire

// [logic/cevr_sync.sv]
// two-stage synchroniser for the asynchronous comparator outputs
`timescale 1ns/1ps
`default_nettype none
module cevr_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cevr_sync_s;
	cevr_sync_s s;
	cevr_sync_s n;
	always_comb
	begin
		n = s;
		n.s1 = asyncIn;
		n.s2 = s.s1; // RL16
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s <= '0;
		else
			s <= n;
	end
	assign syncOut = s.s2;
endmodule : cevr_sync
`default_nettype wire

// [logic/cevr_chan.sv]
// one comparator: polarity, edge selection, sticky event flag and pin data
`timescale 1ns/1ps
`default_nettype none
module cevr_chan
	import cevr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       enable,
	input  wire logic       invert,
	input  wire logic       pinDrive,
	input  wire logic [1:0] edgeSel,
	input  wire logic       rawIn,
	input  wire logic       flagClr,
	output logic            result,
	output logic            flag,
	output logic            pinData,
	output logic            evtPulse
);
	typedef struct packed {
		logic prevRaw;
		logic result;
		logic flag;
		logic pinData;
		logic evt;
	} cevr_chan_s;
	cevr_chan_s s;
	cevr_chan_s n;
	logic rise;
	logic fall;
	logic hit;
	// edges are taken on the raw comparison, so a polarity change
	// never looks like an output transition
	always_comb
	begin
		n = s;
		rise = rawIn & ~s.prevRaw;
		fall = ~rawIn & s.prevRaw;
		unique case (cevr_edge_e'(edgeSel))
			EDGE_NONE: hit = 1'b0; // RL8
			EDGE_RISE: hit = rise; // RL7
			EDGE_FALL: hit = fall; // RL6
			EDGE_ANY:  hit = rise | fall; // RL5
		endcase
		n.prevRaw = rawIn; // RL16
		n.evt = enable & ~s.flag & hit; // RL1 RL4
		n.flag = n.evt | (s.flag & ~flagClr); // RL4
		n.result = enable & (rawIn ^ invert); // RL1 RL3
		n.pinData = pinDrive & n.result; // RL2
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s <= '0;
		else
			s <= n;
	end
	assign result   = s.result;
	assign flag     = s.flag;
	assign pinData  = s.pinData;
	assign evtPulse = s.evt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence sRiseSeen;
		$rose(rawIn) && enable && !s.flag && edgeSel == 2'b01;
	endsequence
	sequence sFallSeen;
		$fell(rawIn) && enable && !s.flag && edgeSel == 2'b10;
	endsequence
	a_rise_event: assert property (sRiseSeen |=> evtPulse && flag) // RL7
		else $error("rising edge gave no event");
	a_fall_event: assert property (sFallSeen |=> evtPulse && flag) // RL6
		else $error("falling edge gave no event");
	a_any_edge: assert property ((rawIn != $past(rawIn)) && enable && !flag && edgeSel == 2'b11 |=> evtPulse) // RL5
		else $error("change gave no event");
	a_none_quiet: assert property (edgeSel == 2'b00 |=> !evtPulse) // RL8
		else $error("event with events disabled");
	a_flag_blocks: assert property (flag |=> !evtPulse) // RL4
		else $error("event while flag set");
	a_off_quiet: assert property (!enable |=> !evtPulse && !result && !pinData) // RL1
		else $error("disabled comparator active");
	a_polarity: assert property (enable ##1 enable |-> result == ($past(rawIn) ^ $past(invert))) // RL3
		else $error("result polarity wrong");
	a_flag_clear: assert property ($fell(flag) |-> $past(flagClr) && !evtPulse) // RL4
		else $error("flag fell without clear");
endmodule : cevr_chan
`default_nettype wire

// [logic/cevr_top.sv]
// comparator and reference control: register slave, three comparators, interrupt
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cevr_defs.svh"
// Summary of operation
// [RL1] comparator acts only while enabled
// [RL2] pin drive bit puts result on pin
// [RL3] result bit follows comparison, polarity inverts
// [RL4] sticky flag set, blocks further events
// [RL5] code 11 events on any change
// [RL6] code 10 falls, or rises when inverted; the code takes raw comparison falls, whatever the invert bit
// [RL7] code 01 rises, or falls when inverted; the code takes raw comparison rises, whatever the invert bit
// [RL8] code 00 gives no events
// [RL9] plus input picks reference or pin A
// [RL10] minus select picks B, C, D, bandgap
// [RL11] unimplemented bits ignore writes, read zero
// [RL12] reference outputs only while enabled
// [RL13] level code scales source over 32
// [RL14] reference pin connect bit
// [RL15] source select supply, external, ground
// [RL16] synchronise comparator outputs before edges
// [RL17] software clears flag after service
module cevr_top
	import cevr_pkg::*;
#(
	parameter int NCMP = 3,
	parameter int AW   = 16
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [AW-1:0]     addr,
	input  wire logic [31:0]       wrData,
	input  wire logic              wrStb,
	input  wire logic              rdStb,
	output logic      [31:0]       rdData,
	input  wire logic [NCMP-1:0]   cmpRaw,
	output logic      [NCMP-1:0]   cmpPowerOn,
	output logic      [NCMP-1:0]   plusUseRef,
	output logic      [2*NCMP-1:0] minusSel,
	output logic                   refPick,
	output logic      [NCMP-1:0]   cmpPinOut,
	output logic      [NCMP-1:0]   cmpPinOe_n,
	output logic      [NCMP-1:0]   cmpTrig,
	output logic                   refPowerOn,
	output logic      [4:0]        refLevelCode,
	output logic                   refPinConnect,
	output logic                   refSrcSupply,
	output logic                   refSrcExtPin,
	output logic                   irq
);
	// status and interrupt words hold one bit per comparator; three fit the map
	generate
		if (NCMP < 1 || NCMP > 3)
		begin : gBadCount
			$error("NCMP must be 1 to 3");
		end
		if (AW < 14 || AW > 32)
		begin : gBadAddr
			$error("AW must be 14 to 32");
		end
	endgenerate

	typedef struct packed {
		cevr_cmpctl_s [NCMP-1:0] cmp;
		cevr_refctl_s            refc;
		logic                    refPick;
		logic [NCMP-1:0]         irqStat;
		logic [NCMP-1:0]         irqMask;
		logic [31:0]             rdData;
	} cevr_top_s;

	cevr_top_s s;
	cevr_top_s n;

	logic [NCMP-1:0] rawSync;
	logic [NCMP-1:0] chResult;
	logic [NCMP-1:0] chFlag;
	logic [NCMP-1:0] chPin;
	logic [NCMP-1:0] chEvt;
	logic [NCMP-1:0] flagClr;
	logic [NCMP-1:0] cmpWrHit;
	logic [NCMP-1:0] cmpRdHit;
	logic [31:0]     rdWord;

	function automatic logic [AW-1:0] cmpOfs(input int idx);
		logic [31:0] full;
		full = `CEVR_OFS_CMP1 + `CEVR_CMP_STRIDE * 32'(idx);
		return full[AW-1:0];
	endfunction : cmpOfs

	function automatic logic [AW-1:0] ofs(input logic [31:0] full);
		return full[AW-1:0];
	endfunction : ofs

	// cores answer asynchronously; only the second stage is read, never the first
	cevr_sync #(
		.W(NCMP)
	) uSync (
		.clk     (clk),
		.reset   (reset),
		.asyncIn (cmpRaw),
		.syncOut (rawSync)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NCMP; gi++)
		begin : gChan
			cevr_chan uChan (
				.clk      (clk),
				.reset    (reset),
				.enable   (s.cmp[gi].en),
				.invert   (s.cmp[gi].inv),
				.pinDrive (s.cmp[gi].pinDrv),
				.edgeSel  (s.cmp[gi].edgeSel),
				.rawIn    (rawSync[gi]),
				.flagClr  (flagClr[gi]),
				.result   (chResult[gi]),
				.flag     (chFlag[gi]),
				.pinData  (chPin[gi]),
				.evtPulse (chEvt[gi])
			);
		end
	endgenerate

	// comparator address decode for the write path; the read path decodes on its own
	always_comb
	begin
		for (int i = 0; i < NCMP; i++)
		begin
			cmpWrHit[i] = wrStb && addr == cmpOfs(i);
			cmpRdHit[i] = rdStb && addr == cmpOfs(i);
			// writing one to the flag bit clears it; RL17
			flagClr[i] = cmpWrHit[i] && wrData[`CEVR_B_FLAG];
		end
	end

	// read word assembly; undefined bits stay zero
	always_comb
	begin
		rdWord = `CEVR_RST_WORD;
		if (addr == ofs(`CEVR_OFS_STAT))
		begin
			rdWord[`CEVR_B_PICK] = s.refPick;
			for (int i = 0; i < NCMP; i++)
			begin
				rdWord[`CEVR_B_STFLAG + i] = chFlag[i];
				rdWord[i] = chResult[i];
			end
		end
		else if (addr == ofs(`CEVR_OFS_REF))
		begin
			rdWord[`CEVR_B_LEVEL +: 5] = s.refc.level;
			rdWord[`CEVR_B_REFON] = s.refc.en;
			rdWord[`CEVR_B_REFOE] = s.refc.pinOe;
			rdWord[`CEVR_B_REFSRC +: 2] = s.refc.src;
		end
		else if (addr == ofs(`CEVR_OFS_IRQST))
			rdWord[NCMP-1:0] = s.irqStat;
		else if (addr == ofs(`CEVR_OFS_IRQMSK))
			rdWord[NCMP-1:0] = s.irqMask;
		else
		begin
			for (int i = 0; i < NCMP; i++)
			begin
				if (addr == cmpOfs(i))
				begin
					rdWord[`CEVR_B_ON] = s.cmp[i].en;
					rdWord[`CEVR_B_PINDRV] = s.cmp[i].pinDrv;
					rdWord[`CEVR_B_INV] = s.cmp[i].inv;
					rdWord[`CEVR_B_FLAG] = chFlag[i]; // RL4
					rdWord[`CEVR_B_RES] = chResult[i]; // RL3
					rdWord[`CEVR_B_EDGE +: 2] = s.cmp[i].edgeSel;
					rdWord[`CEVR_B_PLUS] = s.cmp[i].plusSel;
					rdWord[`CEVR_B_MINUS +: 2] = s.cmp[i].minusSel;
				end
			end
		end
	end

	always_comb
	begin
		n = s;
		// read data stands only in the cycle after the strobe
		n.rdData = rdStb ? rdWord : `CEVR_RST_WORD;
		for (int i = 0; i < NCMP; i++)
		begin
			// only defined fields are stored, the rest is dropped; RL11
			if (cmpWrHit[i])
			begin
				n.cmp[i].en = wrData[`CEVR_B_ON]; // RL1
				n.cmp[i].pinDrv = wrData[`CEVR_B_PINDRV]; // RL2
				n.cmp[i].inv = wrData[`CEVR_B_INV]; // RL3
				n.cmp[i].edgeSel = wrData[`CEVR_B_EDGE +: 2];
				n.cmp[i].plusSel = wrData[`CEVR_B_PLUS]; // RL9
				n.cmp[i].minusSel = wrData[`CEVR_B_MINUS +: 2]; // RL10
			end
		end
		if (wrStb && addr == ofs(`CEVR_OFS_STAT))
			n.refPick = wrData[`CEVR_B_PICK]; // RL9
		if (wrStb && addr == ofs(`CEVR_OFS_REF))
		begin
			n.refc.en = wrData[`CEVR_B_REFON]; // RL12
			n.refc.level = wrData[`CEVR_B_LEVEL +: 5]; // RL13
			n.refc.pinOe = wrData[`CEVR_B_REFOE]; // RL14
			n.refc.src = wrData[`CEVR_B_REFSRC +: 2]; // RL15
		end
		if (wrStb && addr == ofs(`CEVR_OFS_IRQMSK))
			n.irqMask = wrData[NCMP-1:0];
		// a new event beats a write-one clear in the same cycle
		if (wrStb && addr == ofs(`CEVR_OFS_IRQST))
			n.irqStat = s.irqStat & ~wrData[NCMP-1:0];
		n.irqStat = n.irqStat | chEvt;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s <= '0;
		else
			s <= n;
	end

	assign rdData = s.rdData;
	assign irq = |(s.irqStat & s.irqMask);
	assign cmpTrig = chEvt; // RL4
	assign cmpPinOut = chPin; // RL2
	assign refPick = s.refPick;

	// analog controls come straight from registers, so the cores never see decode glitches
	always_comb
	begin
		for (int i = 0; i < NCMP; i++)
		begin
			cmpPowerOn[i] = s.cmp[i].en; // RL1
			// low enable drives the pin only when on and routed; RL2
			cmpPinOe_n[i] = ~(s.cmp[i].en & s.cmp[i].pinDrv);
			plusUseRef[i] = s.cmp[i].plusSel; // RL9
			minusSel[2*i +: 2] = s.cmp[i].minusSel; // RL10
		end
	end

	// ladder is gated off while disabled, so code is forced low too
	assign refPowerOn = s.refc.en; // RL12
	assign refLevelCode = s.refc.en ? s.refc.level : 5'h00; // RL13
	assign refPinConnect = s.refc.en & s.refc.pinOe; // RL14
	// codes 10 and 00 leave both sources off: output sits at ground
	assign refSrcSupply = s.refc.en & (s.refc.src == 2'b11); // RL15
	assign refSrcExtPin = s.refc.en & (s.refc.src == 2'b01); // RL15

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_pin_drive: assert property (cmpPinOut == (chResult & ~cmpPinOe_n) || $changed(s.cmp)) // RL2
		else $error("pin data not gated by drive enable");
	a_reserved_zero: assert property (rdStb && addr == ofs(`CEVR_OFS_REF) |=> rdData[31:21] == 11'h000 && rdData[14:9] == 6'h00) // RL11
		else $error("reserved reference bits not zero");
	a_ref_off: assert property (!refPowerOn |-> refLevelCode == 5'h00 && !refPinConnect && !refSrcSupply) // RL12
		else $error("reference active while off");
	a_ref_source: assert property (refPowerOn && s.refc.src[0] == 1'b0 |-> !refSrcSupply && !refSrcExtPin) // RL15
		else $error("source selected for ground code");
	a_irq_sticky: assert property (|chEvt |=> |s.irqStat) // RL4
		else $error("event lost from status");

	// bus steps are named once, so each property reads as cause and effect
	sequence sRefWrite;
		wrStb && addr == ofs(`CEVR_OFS_REF);
	endsequence
	sequence sRefRead;
		rdStb && addr == ofs(`CEVR_OFS_REF);
	endsequence
	sequence sStatRead;
		rdStb && addr == ofs(`CEVR_OFS_STAT);
	endsequence
	sequence sCmpWrite;
		wrStb && addr == cmpOfs(0);
	endsequence
	sequence sCmpRead;
		rdStb && addr == cmpOfs(0);
	endsequence
	sequence sIrqClear;
		wrStb && addr == ofs(`CEVR_OFS_IRQST);
	endsequence
	sequence sMaskWrite;
		wrStb && addr == ofs(`CEVR_OFS_IRQMSK);
	endsequence

	// reference: a write with the enable set must reach the ladder controls one cycle later
	a_ref_level: assert property ((sRefWrite ##0 wrData[`CEVR_B_REFON]) |=> // RL13
		refPowerOn && refLevelCode == $past(wrData[`CEVR_B_LEVEL +: 5]))
		else $error("reference level not applied");
	a_ref_disable: assert property ((sRefWrite ##0 !wrData[`CEVR_B_REFON]) |=> // RL12
		!refPowerOn && !refPinConnect && !refSrcExtPin)
		else $error("reference still on after disable");
	a_ref_pin: assert property ((sRefWrite ##0 wrData[`CEVR_B_REFON]) |=> // RL14
		refPinConnect == $past(wrData[`CEVR_B_REFOE]))
		else $error("reference pin switch wrong");
	a_ref_codes: assert property ((sRefWrite ##0 wrData[`CEVR_B_REFON]) |=> // RL15
		refSrcSupply == ($past(wrData[`CEVR_B_REFSRC +: 2]) == 2'b11) &&
		refSrcExtPin == ($past(wrData[`CEVR_B_REFSRC +: 2]) == 2'b01))
		else $error("reference source decode wrong");
	a_ref_readback: assert property (sRefRead |=> // RL13
		rdData[`CEVR_B_LEVEL +: 5] == $past(s.refc.level) && rdData[`CEVR_B_REFON] == $past(s.refc.en))
		else $error("reference word read back wrong");

	// status: flag copies must agree with the channels, and every hole reads zero
	a_stat_flags: assert property (sStatRead |=> rdData[`CEVR_B_STFLAG +: NCMP] == $past(chFlag)) // RL4
		else $error("status flag copy wrong");
	a_stat_holes: assert property (sStatRead |=> // RL11
		rdData[31:19] == 13'h0000 && rdData[15:9] == 7'h00 && rdData[7:3] == 5'h00)
		else $error("status reserved bits not zero");

	// first comparator stands for all three: the channel logic is one shared module
	a_cmp_power: assert property (sCmpWrite |=> cmpPowerOn[0] == $past(wrData[`CEVR_B_ON])) // RL1
		else $error("comparator enable not applied");
	a_cmp_pin_oe: assert property (sCmpWrite |=> // RL2
		cmpPinOe_n[0] == !($past(wrData[`CEVR_B_ON]) && $past(wrData[`CEVR_B_PINDRV])))
		else $error("pin enable does not follow drive bit");
	a_cmp_plus: assert property (sCmpWrite |=> plusUseRef[0] == $past(wrData[`CEVR_B_PLUS])) // RL9
		else $error("plus input route not applied");
	a_cmp_minus: assert property (sCmpWrite |=> minusSel[1:0] == $past(wrData[`CEVR_B_MINUS +: 2])) // RL10
		else $error("minus input route not applied");
	a_cmp_holes: assert property (sCmpRead |=> // RL11
		rdData[31:16] == 16'h0000 && rdData[12:10] == 3'h0 && rdData[5] == 1'b0 && rdData[3:2] == 2'h0)
		else $error("comparator reserved bits not zero");
	a_flag_clear_wr: assert property ((sCmpWrite ##0 (wrData[`CEVR_B_FLAG] && chFlag[0])) |=> !chFlag[0]) // RL4
		else $error("flag not cleared by write");

	// interrupt side: a trigger always leaves its flag behind, and a clean clear sticks
	a_trig_flag: assert property (|cmpTrig |-> (cmpTrig & ~chFlag) == {NCMP{1'b0}}) // RL4
		else $error("trigger without flag");
	a_irq_clear: assert property ((sIrqClear ##0 (wrData[0] && !chEvt[0])) |=> !s.irqStat[0]) // RL4
		else $error("status bit not cleared");
	a_mask_write: assert property (sMaskWrite |=> s.irqMask == $past(wrData[NCMP-1:0])) // RL4
		else $error("mask not written");
	a_unmapped_zero: assert property (rdStb && addr == ofs(`CEVR_OFS_STAT + 32'h0000_0004) |=> // RL11
		rdData == `CEVR_RST_WORD)
		else $error("unmapped word not zero");
	a_irq_raise: assert property (|(chEvt & s.irqMask) && !(wrStb && addr == ofs(`CEVR_OFS_IRQMSK)) |=> // RL4
		irq)
		else $error("unmasked event raised no interrupt");
endmodule : cevr_top
`default_nettype wire

// [verification/cevr_analog_model.sv]
// behavioural comparator cores, input muxes and reference sources
`timescale 1ns/1ps
`default_nettype none
module cevr_analog_model
	import cevr_pkg::*;
#(
	parameter int NCMP = 3,
	parameter logic [3:0] BANDGAP = 4'h6,
	parameter logic [3:0] EXTREF  = 4'hA
) (
	input  wire logic              clk,
	input  wire logic [NCMP-1:0]   powerOn,
	input  wire logic [NCMP-1:0]   plusRef,
	input  wire logic [2*NCMP-1:0] minusSel,
	input  wire logic              refPick,
	input  wire logic [4*NCMP-1:0] pinA,
	output logic      [NCMP-1:0]   raw
);
	logic [3:0] plusV;
	logic [3:0] minusV;
	initial raw = '0;
	always @(posedge clk)
	begin
		for (int i = 0; i < NCMP; i++)
		begin
			plusV = plusRef[i] ? (refPick ? EXTREF : BANDGAP) : pinA[4*i+:4];
			case (minusSel[2*i+:2])
				2'h0: minusV = 4'h4;
				2'h1: minusV = 4'h8;
				2'h2: minusV = 4'hC;
				default: minusV = BANDGAP;
			endcase
			// a core that is off has no defined output, so it chatters
			raw[i] <= powerOn[i] ? (plusV > minusV) : ~raw[i];
		end
	end
endmodule : cevr_analog_model
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the comparator and reference control block
`timescale 1ns/1ps
`default_nettype none
`include "cevr_defs.svh"
module tb_top;
	import cevr_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wrData = 32'h0000_0000;
	logic        wrStb = 1'b0;
	logic        rdStb = 1'b0;
	logic [31:0] rdData;
	logic [2:0]  cmpRaw, cmpPowerOn, plusUseRef, cmpPinOut, cmpPinOe_n, cmpTrig;
	logic [5:0]  minusSel;
	logic [4:0]  refLevelCode;
	logic        refPick, refPowerOn, refPinConnect, refSrcSupply, refSrcExtPin, irq;
	logic [11:0] pinA = 12'h000;
	logic [31:0] d;
	logic [31:0] cfg;
	int          fail_count = 0;
	int          num_checks = 0;
	int          trigCnt = 0;
	int          tc0;
	localparam logic [31:0] C1 = `CEVR_OFS_CMP1;
	localparam logic [31:0] C2 = `CEVR_OFS_CMP1 + `CEVR_CMP_STRIDE;
	cevr_top i_dut (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .cmpRaw(cmpRaw), .cmpPowerOn(cmpPowerOn),
		.plusUseRef(plusUseRef), .minusSel(minusSel), .refPick(refPick), .cmpPinOut(cmpPinOut),
		.cmpPinOe_n(cmpPinOe_n), .cmpTrig(cmpTrig), .refPowerOn(refPowerOn),
		.refLevelCode(refLevelCode), .refPinConnect(refPinConnect), .refSrcSupply(refSrcSupply),
		.refSrcExtPin(refSrcExtPin), .irq(irq));
	cevr_analog_model i_ana (.clk(clk), .powerOn(cmpPowerOn), .plusRef(plusUseRef),
		.minusSel(minusSel), .refPick(refPick), .pinA(pinA), .raw(cmpRaw));
	always #2 clk = ~clk;
	always @(posedge clk)
		if (cmpTrig[0] === 1'b1)
			trigCnt++;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a[15:0];
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		addr <= a[15:0];
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		d = rdData;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	// generous bound: the sequence needs well under a thousand cycles
	initial
	begin
		#40000;
		fail_count++;
		results();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// reset values, including three unmapped words
		for (int i = 0; i < 8; i++)
		begin
			rd(`CEVR_OFS_STAT + 32'h0000_0010 * 32'(i));
			chk(d, `CEVR_RST_WORD);
		end
		rd(32'h2304);
		chk(d, 32'h0);
		chk(32'(cmpPinOe_n), 32'h7);
		$display("reset test done");
		wr(`CEVR_OFS_REF, 32'hFFFF_FFFF);
		rd(`CEVR_OFS_REF);
		chk(d, 32'h001F_8103);
		chk(32'(refPinConnect), 32'h1);
		for (int s = 0; s < 4; s++)
		begin
			wr(`CEVR_OFS_REF, 32'h000B_8000 | s);
			chk(32'({refPowerOn, refLevelCode, refPinConnect}), 32'h56);
			chk(32'({refSrcSupply, refSrcExtPin}), 32'({s == 3, s == 1}));
		end
		wr(`CEVR_OFS_REF, 32'h001F_0103);
		chk(32'({refPowerOn, refLevelCode, refPinConnect, refSrcSupply, refSrcExtPin}), 32'h0);
		$display("reference test done");
		wr(C2, 32'hFFFF_1C2C);
		rd(C2);
		chk(d, 32'h0);
		wr(C1, 32'h0000_60D3);
		rd(C1);
		chk(d, 32'h0000_60D3);
		chk(32'({plusUseRef[0], minusSel[1:0], cmpPowerOn[0], cmpPinOe_n[0]}), 32'h1D);
		pinA <= 12'h070;
		for (int m = 0; m < 4; m++)
		begin
			wr(C2, 32'h0000_C000 | m);
			cyc(5);
			rd(C2);
			chk(32'(d[8]), 32'(m == 0 || m == 3));
			chk(32'({cmpPinOut[1], cmpPinOe_n[1]}), 32'({m == 0 || m == 3, 1'b0}));
		end
		wr(C2, 32'h0000_E000);
		cyc(5);
		rd(C2);
		chk(32'(d[8]), 32'h0);
		wr(`CEVR_OFS_STAT, 32'h0000_0100);
		wr(C2, 32'h0000_8011);
		cyc(5);
		rd(C2);
		chk(32'({d[8], refPick}), 32'h3);
		wr(`CEVR_OFS_STAT, 32'h0);
		cyc(5);
		rd(`CEVR_OFS_STAT);
		chk(d, 32'h0);
		$display("routing test done");
		wr(`CEVR_OFS_IRQMSK, 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			pinA <= 12'h070;
			cfg = 32'h8200 | (32'(k & 1) << 13) | (32'(k >> 1) << 6);
			wr(C1, cfg);
			cyc(6);
			wr(C1, cfg);
			wr(`CEVR_OFS_IRQST, 32'h1);
			tc0 = trigCnt;
			pinA <= 12'h075;
			cyc(6);
			chk(trigCnt - tc0, 32'(k / 2 == 1 || k / 2 == 3));
			rd(C1);
			chk(32'({d[9], irq}), (k / 2 == 1 || k / 2 == 3) ? 32'h3 : 32'h0);
			wr(C1, cfg);
			wr(`CEVR_OFS_IRQST, 32'h1);
			chk(32'(irq), 32'h0);
			tc0 = trigCnt;
			pinA <= 12'h070;
			cyc(6);
			chk(trigCnt - tc0, 32'(k / 2 >= 2));
		end
		$display("edge test done");
		wr(C1, 32'h82C0);
		tc0 = trigCnt;
		pinA <= 12'h075;
		cyc(6);
		pinA <= 12'h070;
		cyc(6);
		chk(trigCnt - tc0, 32'h1);
		wr(`CEVR_OFS_IRQMSK, 32'h0);
		chk(32'(irq), 32'h0);
		wr(`CEVR_OFS_IRQMSK, 32'h1);
		chk(32'(irq), 32'h1);
		wr(C1, 32'h82C0);
		pinA <= 12'h075;
		cyc(6);
		chk(trigCnt - tc0, 32'h2);
		wr(C1, 32'h02C0);
		tc0 = trigCnt;
		pinA <= 12'h070;
		cyc(6);
		chk(trigCnt - tc0, 32'h0);
		$display("sticky and disable test done");
		results();
	end
endmodule : tb_top
`default_nettype wire
